// File: spi_eeprom_command_protect.sv
// serial eeprom instruction decode, write latch, block and hardware protection
// assumes an spi master in mode 0 or 3; all pins are sampled by mclk
`timescale 1ns/1ps
`include "spi_eeprom_map.svh"

module spi_eeprom_command_protect
  #(parameter int unsigned WR_CYCLES = `WR_CYCLES)
  (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // serial pins
  input  wire logic       cs_n,
  input  wire logic       sck,
  input  wire logic       si,
  input  wire logic       wp_n,
  output logic            so,
  output logic            so_oe,
  // state seen by the system
  output logic            busy,
  output logic            write_latch,
  output logic [1:0]      protect_level,
  output logic            hw_protect_enable,
  output logic            id_locked
  );
  import spi_eeprom_pkg::*;

  // storage
  logic [7:0]  mem        [0:2047];
  logic [7:0]  id_page    [0:`PAGE_BYTES-1];
  logic [7:0]  page_buf   [0:`PAGE_BYTES-1];

  // pin synchronisers
  logic        cs_q1, cs_q2, cs_q3;
  logic        sck_q1, sck_q2, sck_q3;
  logic        si_q1, si_q2;
  logic        wp_q1, wp_q2;

  // control state
  phase_e      phase, next_phase;
  op_e         op, next_op;
  job_e        job, next_job;
  logic [2:0]  bit_cnt, next_bit_cnt;
  logic [7:0]  shreg, next_shreg;
  logic        addr_byte, next_addr_byte;
  logic [10:0] addr, next_addr;
  logic [7:0]  din, next_din;
  logic        got_data, next_got_data;
  logic [4:0]  ptr, next_ptr;
  logic [31:0] pvalid, next_pvalid;
  logic [7:0]  out_sr, next_out_sr;
  logic [2:0]  out_cnt, next_out_cnt;
  logic        next_so, next_so_oe, next_busy, next_write_latch;
  logic [1:0]  next_protect_level;
  logic        next_hw_protect_enable, next_id_locked;
  logic [31:0] wr_cnt, next_wr_cnt;
  logic [5:0]  cidx, next_cidx;

  // combinational helpers
  logic        sck_rise, sck_fall, cs_rise, selected, hw_prot;
  logic [7:0]  byte_in, status_byte, opc, rd_byte;
  logic        buf_we, mem_we, id_we;
  logic [10:0] commit_addr;

  // a flat address compare is cheaper than a range table
  function automatic logic is_protected(input logic [1:0] lvl, input logic [10:0] a);
    unique case (lvl)
      2'h0:    is_protected = 1'b0;
      2'h1:    is_protected = (a >= `PROT_QUARTER);
      2'h2:    is_protected = (a >= `PROT_HALF);
      default: is_protected = 1'b1;
    endcase
  endfunction

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cs_q1  <= 1'b1;
      cs_q2  <= 1'b1;
      cs_q3  <= 1'b1;
      sck_q1 <= 1'b0;
      sck_q2 <= 1'b0;
      sck_q3 <= 1'b0;
      si_q1  <= 1'b0;
      si_q2  <= 1'b0;
      wp_q1  <= 1'b1;
      wp_q2  <= 1'b1;
    end else begin
      cs_q1  <= cs_n;
      cs_q2  <= cs_q1;
      cs_q3  <= cs_q2;
      sck_q1 <= sck;
      sck_q2 <= sck_q1;
      sck_q3 <= sck_q2;
      si_q1  <= si;
      si_q2  <= si_q1;
      wp_q1  <= wp_n;
      wp_q2  <= wp_q1;
    end
  end

  assign selected    = ~cs_q2;
  assign sck_rise    = selected & sck_q2 & ~sck_q3;
  assign sck_fall    = selected & ~sck_q2 & sck_q3;
  assign cs_rise     = cs_q2 & ~cs_q3;
  assign hw_prot     = hw_protect_enable & ~wp_q2;
  assign byte_in     = {shreg[6:0], si_q2};
  assign opc         = byte_in & `OP_IGNORE_MASK;
  assign status_byte = busy ? `SR_ALL_ONES :
                       {hw_protect_enable, 3'h0, protect_level, write_latch, 1'b0};
  assign commit_addr = {addr[10:5], cidx[4:0]};

  always_comb begin
    next_phase             = phase;
    next_op                = op;
    next_job               = job;
    next_bit_cnt           = bit_cnt;
    next_shreg             = shreg;
    next_addr_byte         = addr_byte;
    next_addr              = addr;
    next_din               = din;
    next_got_data          = got_data;
    next_ptr               = ptr;
    next_pvalid            = pvalid;
    next_out_sr            = out_sr;
    next_out_cnt           = out_cnt;
    next_so                = so;
    next_so_oe             = so_oe;
    next_busy              = busy;
    next_write_latch       = write_latch;
    next_protect_level     = protect_level;
    next_hw_protect_enable = hw_protect_enable;
    next_id_locked         = id_locked;
    next_wr_cnt            = wr_cnt;
    next_cidx              = cidx;
    buf_we                 = 1'b0;
    rd_byte                = mem[addr];
    if (op == OP_XRD) begin
      rd_byte = addr[`ID_SELECT_BIT] ? {7'h0, id_locked} : id_page[addr[4:0]];
    end
    // internal write cycle
    if (busy) begin
      if (!cidx[5]) begin
        next_cidx = cidx + 6'h1;
      end
      if (wr_cnt == 32'h0) begin
        next_busy        = 1'b0;
        next_write_latch = 1'b0;
        next_job         = JOB_NONE;
        if (job == JOB_STATUS) begin
          next_protect_level = din[`SR_PL_HI:`SR_PL_LO];
          next_hw_protect_enable = din[`SR_HPE] | (hw_protect_enable & ~wp_q2);
        end
        if (job == JOB_LOCK) begin
          next_id_locked = 1'b1;
        end
      end else begin
        next_wr_cnt = wr_cnt - 32'h1;
      end
    end
    if (!selected) begin
      next_phase     = PH_CMD;
      next_bit_cnt   = 3'h0;
      next_so_oe     = 1'b0;
      next_addr_byte = 1'b0;
      next_got_data  = 1'b0;
      next_out_cnt   = 3'h0;
    end
    // launch on select rising at a byte boundary only
    if (cs_rise && bit_cnt == 3'h0 && !busy) begin
      if (op == OP_SET && phase == PH_DONE) begin
        next_write_latch = 1'b1;
      end
      if (op == OP_CLR && phase == PH_DONE) begin
        next_write_latch = 1'b0;
      end
      if (op == OP_SWR && phase == PH_DONE && write_latch && !hw_prot) begin
        next_job = JOB_STATUS;
      end
      if (op == OP_AWR && got_data && write_latch) begin
        next_job = JOB_ARRAY;
      end
      if (op == OP_XWR && got_data && write_latch && !id_locked) begin
        if (!addr[`ID_SELECT_BIT]) begin
          next_job = JOB_ID;
        end else if (protect_level != 2'h3 && din[`LOCK_DATA_BIT]) begin
          next_job = JOB_LOCK;
        end
      end
      if (next_job != JOB_NONE) begin
        next_busy   = 1'b1;
        next_wr_cnt = WR_CYCLES - 32'h1;
        next_cidx   = 6'h0;
      end
    end
    if (sck_rise) begin
      next_shreg   = byte_in;
      next_bit_cnt = bit_cnt + 3'h1;
      if (bit_cnt == 3'h7) begin
        unique case (phase)
          PH_CMD: begin
            next_phase = PH_IGNORE;
            next_op    = OP_NONE;
            if (opc == `OP_STATUS_RD) begin
              next_op      = OP_SRD;
              next_phase   = PH_DOUT;
              next_out_sr  = status_byte;
              next_out_cnt = 3'h0;
            end else if (!busy) begin
              if (opc == `OP_SET_LATCH) begin
                next_op    = OP_SET;
                next_phase = PH_DONE;
              end else if (opc == `OP_CLR_LATCH) begin
                next_op    = OP_CLR;
                next_phase = PH_DONE;
              end else if (opc == `OP_STATUS_WR) begin
                next_op    = OP_SWR;
                next_phase = PH_DIN;
              end else if (opc == `OP_ARRAY_RD || opc == `OP_ARRAY_WR ||
                           opc == `OP_ID_RD || opc == `OP_ID_WR) begin
                next_phase = PH_ADDR;
                unique case (opc)
                  `OP_ARRAY_RD: next_op = OP_ARD;
                  `OP_ARRAY_WR: next_op = OP_AWR;
                  `OP_ID_RD:    next_op = OP_XRD;
                  default:      next_op = OP_XWR;
                endcase
              end
            end
          end
          PH_ADDR: begin
            next_addr_byte = 1'b1;
            if (!addr_byte) begin
              next_addr[10:8] = byte_in[2:0];
            end else begin
              next_addr[7:0] = byte_in;
              next_ptr       = byte_in[4:0];
              next_pvalid    = 32'h0;
              if (op == OP_ARD || op == OP_XRD) begin
                next_phase   = PH_DOUT;
                next_out_cnt = 3'h0;
              end else begin
                next_phase = PH_DIN;
              end
            end
          end
          PH_DIN: begin
            next_din      = byte_in;
            next_got_data = 1'b1;
            if (op == OP_SWR) begin
              next_phase = PH_DONE;
            end else begin
              buf_we              = 1'b1;
              next_pvalid[ptr]    = 1'b1;
              next_ptr            = ptr + 5'h1;
            end
          end
          PH_DONE: next_phase = PH_IGNORE;
          default: next_phase = phase;
        endcase
      end
    end
    // read data on falling edges; reload after each eighth bit
    if (sck_fall && phase == PH_DOUT) begin
      next_so_oe   = 1'b1;
      next_out_cnt = out_cnt + 3'h1;
      if (out_cnt == 3'h0) begin
        next_so     = (op == OP_SRD) ? out_sr[7] : rd_byte[7];
        next_out_sr = (op == OP_SRD) ? {out_sr[6:0], 1'b0} : {rd_byte[6:0], 1'b0};
      end else begin
        next_so     = out_sr[7];
        next_out_sr = {out_sr[6:0], 1'b0};
      end
      if (out_cnt == 3'h7) begin
        if (op == OP_SRD) begin
          next_out_sr = status_byte;
        end else if (op == OP_XRD) begin
          next_addr[4:0] = addr[4:0] + 5'h1;
        end else begin
          next_addr = addr + 11'h1;
        end
      end
    end
    // commit one buffered byte per cycle at the start of the write cycle
    mem_we = busy && !cidx[5] && job == JOB_ARRAY && pvalid[cidx[4:0]] &&
             !is_protected(protect_level, commit_addr);
    id_we  = busy && !cidx[5] && job == JOB_ID && pvalid[cidx[4:0]];
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      phase             <= PH_CMD;
      op                <= OP_NONE;
      job               <= JOB_NONE;
      bit_cnt           <= 3'h0;
      shreg             <= 8'h00;
      addr_byte         <= 1'b0;
      addr              <= 11'h000;
      din               <= 8'h00;
      got_data          <= 1'b0;
      ptr               <= 5'h00;
      pvalid            <= 32'h0;
      out_sr            <= 8'h00;
      out_cnt           <= 3'h0;
      so                <= 1'b0;
      so_oe             <= 1'b0;
      busy              <= 1'b0;
      write_latch       <= 1'b0;
      protect_level     <= `PL_RESET;
      hw_protect_enable <= `HPE_RESET;
      id_locked         <= 1'b0;
      wr_cnt            <= 32'h0;
      cidx              <= 6'h20;
    end else begin
      phase             <= next_phase;
      op                <= next_op;
      job               <= next_job;
      bit_cnt           <= next_bit_cnt;
      shreg             <= next_shreg;
      addr_byte         <= next_addr_byte;
      addr              <= next_addr;
      din               <= next_din;
      got_data          <= next_got_data;
      ptr               <= next_ptr;
      pvalid            <= next_pvalid;
      out_sr            <= next_out_sr;
      out_cnt           <= next_out_cnt;
      so                <= next_so;
      so_oe             <= next_so_oe;
      busy              <= next_busy;
      write_latch       <= next_write_latch;
      protect_level     <= next_protect_level;
      hw_protect_enable <= next_hw_protect_enable;
      id_locked         <= next_id_locked;
      wr_cnt            <= next_wr_cnt;
      cidx              <= next_cidx;
    end
  end

  // storage has no reset; the array powers up with whatever it held
  always_ff @(posedge mclk) begin
    if (buf_we) begin
      page_buf[ptr] <= byte_in;
    end
    if (mem_we) begin
      mem[commit_addr] <= page_buf[cidx[4:0]];
    end
    if (id_we) begin
      id_page[cidx[4:0]] <= page_buf[cidx[4:0]];
    end
  end

endmodule

// File: spi_eeprom_map.svh
// constants for the serial eeprom command and protection block
// assumes a 200 MHz core clock sampling every serial pin
`ifndef SPI_EEPROM_MAP_SVH
`define SPI_EEPROM_MAP_SVH

// opcodes compared after masking the ignored bit 3
`define OP_IGNORE_MASK   8'hf7
`define OP_SET_LATCH     8'h06
`define OP_CLR_LATCH     8'h04
`define OP_STATUS_RD     8'h05
`define OP_STATUS_WR     8'h01
`define OP_ARRAY_RD      8'h03
`define OP_ARRAY_WR      8'h02
`define OP_ID_RD         8'h83
`define OP_ID_WR         8'h82

// status register bit positions
`define SR_BUSY          0
`define SR_LATCH         1
`define SR_PL_LO         2
`define SR_PL_HI         3
`define SR_HPE           7
`define SR_ALL_ONES      8'hff

// protected ranges and address fields
`define PROT_QUARTER     11'h600
`define PROT_HALF        11'h400
`define ID_SELECT_BIT    10
`define LOCK_DATA_BIT    1
`define PAGE_BYTES       32

// reset values
`define PL_RESET         2'h0
`define HPE_RESET        1'b0

// internal write cycle
`define CLK_PERIOD_NS    5
`define T_WR_NS          5000000
`define WR_CYCLES        (`T_WR_NS / `CLK_PERIOD_NS)

`endif

// File: spi_eeprom_pkg.sv
// types shared by the serial eeprom command and protection block
// assumes the constants header is included alongside
package spi_eeprom_pkg;
  typedef enum logic [2:0] {PH_CMD, PH_ADDR, PH_DIN, PH_DOUT, PH_DONE, PH_IGNORE} phase_e;
  typedef enum logic [3:0] {OP_NONE, OP_SET, OP_CLR, OP_SRD, OP_SWR, OP_ARD, OP_AWR,
                            OP_XRD, OP_XWR} op_e;
  typedef enum logic [2:0] {JOB_NONE, JOB_STATUS, JOB_ARRAY, JOB_ID, JOB_LOCK} job_e;
endpackage

// File: spi_eeprom_command_protect_assertions.sv
// concurrent checks on the eeprom command block pins
// assumes only the block's ports; attached by bind below
`timescale 1ns/1ps
module spi_eeprom_command_protect_assertions
  #(parameter int unsigned WR_CYCLES = 64)
  (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // serial pins
  input  wire logic       cs_n,
  input  wire logic       sck,
  input  wire logic       si,
  input  wire logic       wp_n,
  input  wire logic       so,
  input  wire logic       so_oe,
  // state
  input  wire logic       busy,
  input  wire logic       write_latch,
  input  wire logic [1:0] protect_level,
  input  wire logic       hw_protect_enable,
  input  wire logic       id_locked
  );
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // a counter, since the write time is far beyond a repetition count
  logic [31:0] busy_cnt;
  logic [31:0] next_busy_cnt;
  always_comb next_busy_cnt = busy ? busy_cnt + 32'h1 : 32'h0;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) busy_cnt <= 32'h0;
    else busy_cnt <= next_busy_cnt;
  end
  a_busy_length: assert property ($fell(busy) |-> busy_cnt == WR_CYCLES)
    else $error("write cycle length wrong");
  a_latch_at_end: assert property ($fell(busy) |-> !write_latch)
    else $error("latch still set after write cycle");
  a_busy_after_cs: assert property ($rose(busy) |-> cs_n && $past(write_latch))
    else $error("write cycle started without latch or inside frame");
  a_config_at_end: assert property (($changed(protect_level) || $changed(hw_protect_enable))
    |-> $fell(busy))
    else $error("status bits changed outside write cycle end");
  a_enable_drop: assert property ($fell(hw_protect_enable) |-> $past(wp_n, 3))
    else $error("protect enable dropped with pin low");
  a_latch_set_idle: assert property ($rose(write_latch) |-> cs_n && !busy)
    else $error("latch set during frame or write cycle");
  a_so_on_fall: assert property (($changed(so) && so_oe) |-> !sck)
    else $error("serial out changed while clock high");
  a_so_release: assert property ($rose(cs_n) |-> ##4 !so_oe)
    else $error("serial out still driven after deselect");
  c_write_cycle: cover property ($rose(busy));
  c_read_out: cover property ($rose(so_oe));
  c_enable_drop: cover property ($fell(hw_protect_enable));
endmodule

bind spi_eeprom_command_protect spi_eeprom_command_protect_assertions #(.WR_CYCLES(WR_CYCLES))
  spi_eeprom_command_protect_assertions_inst (.mclk(mclk), .rst(rst), .cs_n(cs_n),
  .sck(sck), .si(si), .wp_n(wp_n), .so(so), .so_oe(so_oe), .busy(busy),
  .write_latch(write_latch), .protect_level(protect_level),
  .hw_protect_enable(hw_protect_enable), .id_locked(id_locked));

// File: spi_master_model.sv
// spi master model driving the eeprom pins in mode 0
// assumes the bench calls its tasks; half sck period is 16 mclk (80 ns)
`timescale 1ns/1ps
module spi_master_model (
  // clock
  input  wire logic mclk,
  // serial pins
  output logic      cs_n,
  output logic      sck,
  output logic      si,
  input  wire logic so
  );
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
  end
  task automatic half();
    repeat (16) @(posedge mclk);
    #1;
  endtask
  task automatic start();
    cs_n = 1'b0;
    half();
  endtask
  // reply bits are taken at the rise, long after the device moved them
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      si = tx[i];
      half();
      sck = 1'b1;
      rx[i] = so;
      half();
      sck = 1'b0;
    end
  endtask
  task automatic stop();
    half();
    cs_n = 1'b1;
    si = ~si;
  endtask
endmodule

// File: spi_eeprom_command_protect_tb.sv
// self-checking bench for the eeprom command and protection block
// assumes the master model and the checker are compiled first
`timescale 1ns/1ps
module spi_eeprom_command_protect_tb;
  // short write cycle, still longer than the frames sent while busy
  localparam int unsigned WR_CYCLES = 2000;
  logic       mclk = 1'b0;
  logic       rst = 1'b1;
  logic       wp_n = 1'b1;
  logic       cs_n;
  logic       sck;
  logic       si;
  logic       so;
  logic       so_oe;
  logic       so_line;
  logic       busy;
  logic       write_latch;
  logic [1:0] protect_level;
  logic       hw_protect_enable;
  logic       id_locked;
  int         miscompares = 0;
  int         checked = 0;
  logic [7:0] rxq[$];

  spi_eeprom_command_protect #(.WR_CYCLES(WR_CYCLES)) spi_eeprom_command_protect_inst (
    .mclk(mclk), .rst(rst), .cs_n(cs_n), .sck(sck), .si(si), .wp_n(wp_n), .so(so),
    .so_oe(so_oe), .busy(busy), .write_latch(write_latch), .protect_level(protect_level),
    .hw_protect_enable(hw_protect_enable), .id_locked(id_locked));
  spi_master_model spi_master_model_inst (.mclk(mclk), .cs_n(cs_n), .sck(sck), .si(si),
    .so(so_line));
  // a released output shows the inverse, so a sample taken off the drive window is caught
  assign so_line = so_oe ? so : ~so;

  always #2.5 mclk = ~mclk;

  task automatic give_verdict();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic frame(input logic [7:0] tx[$]);
    logic [7:0] r;
    rxq.delete();
    spi_master_model_inst.start();
    foreach (tx[i]) begin
      spi_master_model_inst.xfer(tx[i], r);
      rxq.push_back(r);
    end
    spi_master_model_inst.stop();
    repeat (10) @(posedge mclk);
    #1;
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 3000) begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk({7'h0, busy}, 8'h00, "write cycle did not end");
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d0, input logic [7:0] d1);
    frame({8'h06});
    frame({8'h02, a[15:8], a[7:0], d0, d1});
    wait_idle();
  endtask
  task automatic rd2(input logic [15:0] a, input logic [7:0] e0, input logic [7:0] e1);
    frame({8'h03, a[15:8], a[7:0], 8'h00, 8'h00});
    chk(rxq[3], e0, "read byte 0");
    chk(rxq[4], e1, "read byte 1");
    chk({7'h0, so_oe}, 8'h00, "serial out released");
  endtask

  task automatic t_reset();
    chk({7'h0, busy}, 8'h00, "busy after reset");
    chk({7'h0, write_latch}, 8'h00, "latch after reset");
    chk({6'h0, protect_level}, 8'h00, "levels after reset");
    chk({7'h0, hw_protect_enable}, 8'h00, "enable after reset");
  endtask
  task automatic t_latch();
    logic [7:0] ops[4];
    ops = '{8'h0e, 8'h0c, 8'h06, 8'h04};
    foreach (ops[i]) begin
      frame({ops[i]});
      chk({7'h0, write_latch}, {7'h0, ops[i][1]}, "latch opcode");
    end
    frame({8'h06, 8'h00});
    chk({7'h0, write_latch}, 8'h00, "latch with extra byte");
    frame({8'hff});
    chk({7'h0, write_latch}, 8'h00, "unknown opcode");
  endtask
  // 34 bytes from offset 1eh: the page wraps and the first two are overwritten
  task automatic t_array();
    logic [7:0] q[$];
    q = {8'h02, 8'hf8, 8'h3e};
    for (int i = 0; i < 34; i++) q.push_back(8'(i + 1));
    frame({8'h06});
    frame(q);
    wait_idle();
    chk({7'h0, write_latch}, 8'h00, "latch after array write");
    wr(16'h07ff, 8'ha5, 8'h5a);
    wr(16'h001f, 8'h11, 8'h22);
    wr(16'h0600, 8'h66, 8'h67);
    rd2(16'hf83e, 8'h21, 8'h22);
    rd2(16'h001f, 8'h11, 8'h03);
    rd2(16'h07ff, 8'ha5, 8'h22);
  endtask
  task automatic t_status();
    frame({8'h06});
    frame({8'h01, 8'hfc});
    chk({7'h0, busy}, 8'h01, "status write busy");
    chk({6'h0, protect_level}, 8'h00, "levels held while busy");
    frame({8'h04});
    chk({7'h0, write_latch}, 8'h01, "clear refused while busy");
    frame({8'h05, 8'h00});
    chk(rxq[1], 8'hff, "status while busy");
    wait_idle();
    chk({7'h0, write_latch}, 8'h00, "latch after status write");
    frame({8'h05, 8'h00, 8'h00});
    chk(rxq[1], 8'h8c, "status byte");
    chk(rxq[2], 8'h8c, "status repeated");
    wp_n = 1'b0;
    frame({8'h06});
    frame({8'h01, 8'h04});
    chk({7'h0, busy}, 8'h00, "status write under pin protection");
    frame({8'h04});
    wp_n = 1'b1;
    frame({8'h06});
    frame({8'h01, 8'h04});
    wait_idle();
    chk({hw_protect_enable, 5'h0, protect_level}, 8'h01, "enable dropped, pin high");
  endtask
  // level 01 now guards 600h-7ffh only
  task automatic t_protect();
    wr(16'h07ff, 8'hee, 8'hee);
    wr(16'h05ff, 8'h44, 8'h45);
    wr(16'h0600, 8'h99, 8'h98);
    frame({8'h02, 8'h00, 8'h1f, 8'h77});
    wait_idle();
    rd2(16'h07ff, 8'ha5, 8'h22);
    rd2(16'h05ff, 8'h44, 8'h66);
    rd2(16'h001f, 8'h11, 8'h03);
  endtask
  // id page write and read back, then lock it; a locked page refuses writes
  task automatic t_ident();
    frame({8'h06});
    frame({8'h82, 8'h00, 8'h05, 8'h3c});
    wait_idle();
    frame({8'h83, 8'hf8, 8'h05, 8'h00});
    chk(rxq[3], 8'h3c, "id page byte");
    frame({8'h83, 8'h04, 8'h00, 8'h00});
    chk(rxq[3], 8'h00, "lock state open");
    frame({8'h06});
    frame({8'h82, 8'h04, 8'h00, 8'h02});
    wait_idle();
    chk({7'h0, id_locked}, 8'h01, "page locked");
    chk({7'h0, write_latch}, 8'h00, "latch after lock");
    frame({8'h83, 8'h04, 8'h00, 8'h00, 8'h00});
    chk(rxq[3], 8'h01, "lock state shut");
    chk(rxq[4], 8'h01, "lock state repeated");
    frame({8'h06});
    frame({8'h82, 8'h00, 8'h05, 8'hc3});
    chk({7'h0, busy}, 8'h00, "write to locked page");
    frame({8'h04});
    frame({8'h83, 8'h00, 8'h05, 8'h00});
    chk(rxq[3], 8'h3c, "locked page kept");
  endtask

  initial begin
    repeat (100000) @(posedge mclk);
    miscompares++;
    give_verdict();
  end
  initial begin
    repeat (10) @(posedge mclk);
    #1;
    rst = 1'b0;
    repeat (5) @(posedge mclk);
    #1;
    t_reset();
    t_latch();
    t_array();
    t_status();
    t_protect();
    t_ident();
    give_verdict();
  end
endmodule
